// file: shared/iop_pkg.sv
package iop_pkg;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_DATA = 8'h80;
  localparam logic [7:0] OFS_SET = 8'h84;
  localparam logic [7:0] OFS_CLR = 8'h88;
  localparam logic [7:0] OFS_HSTATE = 8'h8c;
  localparam logic [7:0] OFS_HSET = 8'h90;
  localparam logic [7:0] OFS_HCLR = 8'h94;
  localparam logic [7:0] PORT_MASK = 8'hdf;
  localparam logic [7:0] OFS_CLKSEL = 8'hc0;
  localparam logic [7:0] OFS_PWMAON = 8'hc4;

  // ==========================================================
  // Mode field layout and encodings
  localparam int SEL_LSB = 0;
  localparam int DIR_LSB = 8;
  localparam logic [5:0] SEL_GPIO = 6'h00;
  localparam logic [5:0] SEL_ANALOG = 6'h01;
  localparam logic [5:0] SEL_MAX = 6'h3b;
  localparam logic [1:0] DIR_IN = 2'h0;
  localparam logic [1:0] DIR_PU = 2'h1;
  localparam logic [1:0] DIR_PD = 2'h2;
  localparam logic [1:0] DIR_OUT = 2'h3;

  // ==========================================================
  // Fixed pin positions (port 1 pins add 16)
  localparam int PIN_QSPI_N = 6;
  localparam int PIN_APP_DIO = 6;
  localparam int PIN_APP_CLK = 7;
  localparam int PIN_RAD_DIO = 8;
  localparam int PIN_RAD_CLK = 9;
  localparam int CLK_PIN [4] = '{8, 11, 12, 18};
  localparam int PWM_PIN [2] = '{12, 10};

  // ==========================================================
  // Types and reset values
  typedef struct packed {
    logic [31:0] dout;
    logic [31:0] oe;
    logic [31:0] pu;
    logic [31:0] pd;
    logic [31:0] an;
  } iop_pad_s;

  typedef struct packed {
    logic [31:0][9:0] mode;
    logic [31:0] data;
    logic [31:0] hrel;
    logic [3:0] clksel;
    logic [1:0] pwmaon;
    logic [31:0] s1;
    logic [31:0] s2;
    logic [31:0] s3;
    logic [31:0] lvl;
    logic [59:0] pin_in;
    iop_pad_s pad;
    logic ack;
    logic wreq;
    logic [31:0] rdata;
  } iop_state_s;

  localparam logic [31:0] DATA_RST = 32'h0000_0000;
  localparam logic [31:0] HOLD_RST = 32'hffff_ffff;
  localparam iop_state_s STATE_RST = '{
    mode: '0, data: DATA_RST, hrel: HOLD_RST, clksel: 4'h0,
    pwmaon: 2'h0, s1: 32'h0, s2: 32'h0, s3: 32'h0, lvl: 32'h0,
    pin_in: 60'h0, pad: '0, ack: 1'b0, wreq: 1'b1, rdata: 32'h0};

endpackage

// file: core/iop_pin_router.sv
// Implementation choices: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
module iop_pin_router (
  input wire logic clk_in,                  // System clock
  input wire logic nrst_in,                 // Async reset, low
  input wire logic [7:0] avs_address_in,    // Byte address
  input wire logic avs_read_in,             // Read request
  input wire logic avs_write_in,            // Write request
  input wire logic [31:0] avs_writedata_in, // Write data
  input wire logic [3:0] avs_byteenable_in, // Byte lanes
  output logic [31:0] avs_readdata_out,     // Read data
  output logic avs_waitrequest_out,         // Stall
  input wire logic [31:0] pad_in_in,        // Pin levels
  output iop_pkg::iop_pad_s pad_out,        // Pad controls
  input wire logic [59:0] periph_out_in,    // Peripheral outputs by id
  output logic [59:0] periph_in_out,        // Peripheral inputs by id
  output logic [31:0] fixed_level_out,      // Levels for fixed users
  input wire logic qspi_clk_en_in,          // QSPI clock on
  input wire logic [5:0] qspi_do_in,        // QSPI pad data
  input wire logic [5:0] qspi_oe_in,        // QSPI pad enables
  input wire logic [1:0] dbg_en_in,         // Debug port enables
  input wire logic [1:0] dbg_dio_do_in,     // Debug data out
  input wire logic [1:0] dbg_dio_oe_in,     // Debug data enable
  input wire logic [3:0] int_clk_in,        // Internal clocks
  input wire logic [1:0] pwm_in,            // Timer PWM levels
  input wire logic sleep_in                 // System asleep
);

  // ==========================================================
  // Helpers
  function automatic logic [31:0] be_mask(input logic [3:0] be);
    logic [31:0] m;
    m = 32'h0;
    for (int b = 0; b < 4; b++) begin
      m[b*8 +: 8] = {8{be[b]}};
    end
    return m;
  endfunction

  function automatic logic [31:0] be_merge(input logic [31:0] old,
      input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] m;
    m = be_mask(be);
    return (old & ~m) | (wd & m);
  endfunction

  function automatic logic is_sel_ok(input logic [5:0] sel);
    return (sel != iop_pkg::SEL_GPIO) && (sel <= iop_pkg::SEL_MAX);
  endfunction

  // ==========================================================
  // State
  iop_pkg::iop_state_s q_r;
  iop_pkg::iop_state_s q_nxt;

  // Next-state logic
  always_comb begin
    logic req;
    logic take;
    logic [7:0] addr;
    logic [7:0] poff;
    logic [4:0] pb;
    logic [31:0] wm;
    logic [31:0] rd;
    logic [31:0] anm;
    logic [31:0] lvl_rd;
    logic [59:0] pin_in;
    logic [5:0] sel;
    logic [1:0] dir;
    logic dout;
    logic oe;
    logic pu;
    logic pd;
    logic an;
    logic [31:0] mg;
    req = 1'b0;
    mg = 32'h0;
    take = 1'b0;
    addr = avs_address_in;
    poff = 8'h0;
    pb = 5'h0;
    wm = 32'h0;
    rd = 32'h0;
    anm = 32'h0;
    lvl_rd = 32'h0;
    pin_in = 60'h0;
    sel = 6'h0;
    dir = 2'h0;
    dout = 1'b0;
    oe = 1'b0;
    pu = 1'b0;
    pd = 1'b0;
    an = 1'b0;
    q_nxt = q_r;

    // Three-stage pin sampling, level moves when stages 2 and 3 agree
    q_nxt.s1 = pad_in_in;
    q_nxt.s2 = q_r.s1;
    q_nxt.s3 = q_r.s2;
    q_nxt.lvl = (q_r.s3 & ~(q_r.s2 ^ q_r.s3)) |
                (q_r.lvl & (q_r.s2 ^ q_r.s3));

    // Analog pin mask
    for (int i = 0; i < 32; i++) begin
      anm[i] = q_r.mode[i][iop_pkg::SEL_LSB +: 6] ==
               iop_pkg::SEL_ANALOG;
    end
    lvl_rd = q_r.lvl & ~anm;

    // Bus handshake: one stall cycle, then answer
    req = avs_read_in | avs_write_in;
    take = req & q_r.ack;
    q_nxt.ack = req & ~q_r.ack;
    q_nxt.wreq = ~(req & ~q_r.ack);
    poff = addr & iop_pkg::PORT_MASK;
    pb = {addr[5], 4'h0};

    // Read mux, captured one cycle ahead of the answer
    if (addr[7] == 1'b0) begin
      rd[9:0] = q_r.mode[addr[6:2]];
    end else if (addr == iop_pkg::OFS_CLKSEL) begin
      rd[3:0] = q_r.clksel;
    end else if (addr == iop_pkg::OFS_PWMAON) begin
      rd[1:0] = q_r.pwmaon;
    end else if (addr[6] == 1'b0) begin
      case (poff)
        iop_pkg::OFS_DATA: begin
          rd[15:0] = lvl_rd[pb +: 16];
        end
        iop_pkg::OFS_HSTATE: begin
          rd[15:0] = q_r.hrel[pb +: 16];
        end
        default: begin
          rd = 32'h0;
        end
      endcase
    end
    if (avs_read_in && !q_r.ack) begin
      q_nxt.rdata = rd;
    end

    // Register writes at the accepting edge
    wm = avs_writedata_in & be_mask(avs_byteenable_in);
    if (take && avs_write_in) begin
      if (addr[7] == 1'b0) begin
        mg = be_merge({22'h0, q_r.mode[addr[6:2]]}, avs_writedata_in,
            avs_byteenable_in);
        q_nxt.mode[addr[6:2]] = mg[9:0];
      end else if (addr == iop_pkg::OFS_CLKSEL) begin
        mg = be_merge({28'h0, q_r.clksel}, avs_writedata_in,
            avs_byteenable_in);
        q_nxt.clksel = mg[3:0];
      end else if (addr == iop_pkg::OFS_PWMAON) begin
        mg = be_merge({30'h0, q_r.pwmaon}, avs_writedata_in,
            avs_byteenable_in);
        q_nxt.pwmaon = mg[1:0];
      end else if (addr[6] == 1'b0) begin
        case (poff)
          iop_pkg::OFS_DATA: begin
            mg = be_merge({16'h0, q_r.data[pb +: 16]}, avs_writedata_in,
                avs_byteenable_in);
            q_nxt.data[pb +: 16] = mg[15:0];
          end
          iop_pkg::OFS_SET: begin
            q_nxt.data[pb +: 16] = q_r.data[pb +: 16] | wm[15:0];
          end
          iop_pkg::OFS_CLR: begin
            q_nxt.data[pb +: 16] = q_r.data[pb +: 16] & ~wm[15:0];
          end
          iop_pkg::OFS_HSET: begin
            q_nxt.hrel[pb +: 16] = q_r.hrel[pb +: 16] | wm[15:0];
          end
          iop_pkg::OFS_HCLR: begin
            q_nxt.hrel[pb +: 16] = q_r.hrel[pb +: 16] & ~wm[15:0];
          end
          default: begin
            q_nxt.hrel = q_r.hrel;
          end
        endcase
      end
    end

    // Input routing, walked high to low so the lowest pin wins
    for (int i = 31; i >= 0; i--) begin
      sel = q_r.mode[i][iop_pkg::SEL_LSB +: 6];
      dir = q_r.mode[i][iop_pkg::DIR_LSB +: 2];
      if (is_sel_ok(sel) && !anm[i] && dir != iop_pkg::DIR_OUT) begin
        pin_in[sel] = q_r.lvl[i];
      end
    end
    q_nxt.pin_in = pin_in;

    // Pad control per pin
    for (int i = 0; i < 32; i++) begin
      sel = q_r.mode[i][iop_pkg::SEL_LSB +: 6];
      dir = q_r.mode[i][iop_pkg::DIR_LSB +: 2];
      an = anm[i];
      oe = (dir == iop_pkg::DIR_OUT) && !an;
      pu = (dir == iop_pkg::DIR_PU) && !an;
      pd = (dir == iop_pkg::DIR_PD) && !an;
      if (sel == iop_pkg::SEL_GPIO) begin
        dout = q_r.data[i];
      end else if (is_sel_ok(sel)) begin
        dout = periph_out_in[sel];
      end else begin
        dout = 1'b0;
      end
      // Clock outputs on their own pins
      for (int k = 0; k < 4; k++) begin
        if (q_r.clksel[k] && i == iop_pkg::CLK_PIN[k]) begin
          dout = int_clk_in[k];
          oe = 1'b1;
          pu = 1'b0;
          pd = 1'b0;
          an = 1'b0;
        end
      end
      // Debug wires take their fixed pins
      if ((dbg_en_in[0] && i == iop_pkg::PIN_APP_DIO) ||
          (dbg_en_in[1] && i == iop_pkg::PIN_RAD_DIO)) begin
        dout = (i == iop_pkg::PIN_APP_DIO) ? dbg_dio_do_in[0] :
               dbg_dio_do_in[1];
        oe = (i == iop_pkg::PIN_APP_DIO) ? dbg_dio_oe_in[0] :
             dbg_dio_oe_in[1];
        pu = 1'b0;
        pd = 1'b0;
        an = 1'b0;
      end
      if ((dbg_en_in[0] && i == iop_pkg::PIN_APP_CLK) ||
          (dbg_en_in[1] && i == iop_pkg::PIN_RAD_CLK)) begin
        oe = 1'b0;
        an = 1'b0;
      end
      // Released pads follow live logic, held ones keep the latch
      if (q_r.hrel[i]) begin
        q_nxt.pad.dout[i] = dout;
        q_nxt.pad.oe[i] = oe;
        q_nxt.pad.pu[i] = pu;
        q_nxt.pad.pd[i] = pd;
        q_nxt.pad.an[i] = an;
      end else begin
        q_nxt.pad.dout[i] = q_r.pad.dout[i];
        q_nxt.pad.oe[i] = q_r.pad.oe[i];
        q_nxt.pad.pu[i] = q_r.pad.pu[i];
        q_nxt.pad.pd[i] = q_r.pad.pd[i];
        q_nxt.pad.an[i] = q_r.pad.an[i];
      end
      // QSPI controller owns its pads while clocked, even in hold
      if (i < iop_pkg::PIN_QSPI_N && qspi_clk_en_in) begin
        q_nxt.pad.dout[i] = qspi_do_in[i];
        q_nxt.pad.oe[i] = qspi_oe_in[i];
        q_nxt.pad.pu[i] = 1'b0;
        q_nxt.pad.pd[i] = 1'b0;
        q_nxt.pad.an[i] = 1'b0;
      end
      // Timer PWM kept alive in sleep
      for (int k = 0; k < 2; k++) begin
        if (sleep_in && q_r.pwmaon[k] && i == iop_pkg::PWM_PIN[k]) begin
          q_nxt.pad.dout[i] = pwm_in[k];
          q_nxt.pad.oe[i] = 1'b1;
          q_nxt.pad.pu[i] = 1'b0;
          q_nxt.pad.pd[i] = 1'b0;
          q_nxt.pad.an[i] = 1'b0;
        end
      end
    end
  end

  // State register
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      q_r <= iop_pkg::STATE_RST;
    end else begin
      q_r <= q_nxt;
    end
  end

  // Outputs straight from state
  assign avs_readdata_out = q_r.rdata;
  assign avs_waitrequest_out = q_r.wreq;
  assign pad_out = q_r.pad;
  assign periph_in_out = q_r.pin_in;
  assign fixed_level_out = q_r.lvl;

endmodule

// file: tb/iop_pin_router_sva.sv
`timescale 1ns/1ps
// ==========================================================
// Port checker for the pin router
module iop_pin_router_sva (
  input wire logic clk_in,                  // Clock
  input wire logic nrst_in,                 // Reset, low
  input wire logic [7:0] avs_address_in,    // Address
  input wire logic avs_read_in,             // Read
  input wire logic avs_write_in,            // Write
  input wire logic [31:0] avs_writedata_in, // Write data
  input wire logic [3:0] avs_byteenable_in, // Lanes
  input wire logic [31:0] avs_readdata_out, // Read data
  input wire logic avs_waitrequest_out,     // Stall
  input iop_pkg::iop_pad_s pad_out,         // Pad controls
  input wire logic qspi_clk_en_in,          // QSPI clock on
  input wire logic [5:0] qspi_do_in,        // QSPI data
  input wire logic [5:0] qspi_oe_in,        // QSPI enables
  input wire logic [1:0] dbg_en_in,         // Debug on
  input wire logic [1:0] dbg_dio_do_in,     // Debug data
  input wire logic [1:0] dbg_dio_oe_in      // Debug enable
);
  logic [31:0] hrel_r, hrel_q1, hrel_q2, hrel_q3, wmask, held;
  logic [15:0] wbits;
  logic acc;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  // Shadow of the hold release bits seen on the bus
  assign acc = avs_write_in && !avs_waitrequest_out;
  assign wbits = avs_writedata_in[15:0] &
    {{8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
  assign wmask = avs_address_in[5] ? {wbits, 16'h0} : {16'h0, wbits};
  assign held = ~(hrel_r | hrel_q1 | hrel_q2 | hrel_q3);
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      hrel_r <= '1;
      hrel_q1 <= '1;
      hrel_q2 <= '1;
      hrel_q3 <= '1;
    end else begin
      hrel_q1 <= hrel_r;
      hrel_q2 <= hrel_q1;
      hrel_q3 <= hrel_q2;
      if (acc && (avs_address_in & 8'hdf) == 8'h90) begin
        hrel_r <= hrel_r | wmask;
      end else if (acc && (avs_address_in & 8'hdf) == 8'h94) begin
        hrel_r <= hrel_r & ~wmask;
      end
    end
  end
  // Request phases and pad conditions
  sequence s_req_waiting;
    (avs_read_in || avs_write_in) && avs_waitrequest_out;
  endsequence
  sequence s_dbg_live;
    dbg_en_in[0] && (&hrel_r[7:6]) && (&hrel_q1[7:6]);
  endsequence
  a_wait_one_state: assert property (s_req_waiting |=>
    !avs_waitrequest_out) else $error("answer late");
  a_wait_pulse_once: assert property (!avs_waitrequest_out |=>
    avs_waitrequest_out) else $error("stall low too long");
  a_rdata_holds: assert property ($changed(avs_readdata_out) |->
    $past(avs_read_in)) else $error("read data moved");
  a_unmapped_zero: assert property (avs_read_in &&
    !avs_waitrequest_out && avs_address_in >= 8'hc8 |->
    avs_readdata_out == 32'h0) else $error("unmapped read not zero");
  a_pulls_off: assert property (((pad_out.oe | pad_out.an) &
    (pad_out.pu | pad_out.pd) & 32'hfffb_e000) == 32'h0)
    else $error("pull on while driving");
  a_qspi_follow: assert property (qspi_clk_en_in |=>
    pad_out.dout[5:0] == $past(qspi_do_in) &&
    pad_out.oe[5:0] == $past(qspi_oe_in)) else $error("qspi pads");
  a_debug_pins: assert property (s_dbg_live |=>
    !pad_out.oe[7] && pad_out.dout[6] == $past(dbg_dio_do_in[0]) &&
    pad_out.oe[6] == $past(dbg_dio_oe_in[0])) else $error("debug pins");
  a_hold_frozen: assert property ((((pad_out.dout ^
    $past(pad_out.dout)) | (pad_out.oe ^ $past(pad_out.oe))) & held &
    32'hffff_ebc0) == 32'h0) else $error("held pad changed");
endmodule
bind iop_pin_router iop_pin_router_sva u_sva (.clk_in, .nrst_in,
  .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
  .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out, .pad_out,
  .qspi_clk_en_in, .qspi_do_in, .qspi_oe_in, .dbg_en_in, .dbg_dio_do_in,
  .dbg_dio_oe_in);

// file: tb/iop_far_side.sv
`timescale 1ns/1ps
// ==========================================================
// Board around the pads
module iop_far_side (
  input iop_pkg::iop_pad_s pad_in, // Pad controls
  input wire logic [31:0] ext_in,  // Board drive on free pins
  output logic [31:0] level_out    // Pin levels
);
  // Driven pins show pad data, others pulls or board level
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      if (pad_in.oe[i]) level_out[i] = pad_in.dout[i];
      else if (pad_in.pu[i]) level_out[i] = 1'b1;
      else if (pad_in.pd[i]) level_out[i] = 1'b0;
      else level_out[i] = ext_in[i];
    end
  end
endmodule

// file: tb/test_io_port_pin_router.sv
`timescale 1ns/1ps
// ==========================================================
// Bench for the pin router
module test_io_port_pin_router;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic rd = 1'b0, wr = 1'b0, qen = 1'b0, slp = 1'b0, waitreq;
  logic [7:0] addr = 8'h00;
  logic [31:0] wd = 32'h0, rdata, lvl, got, flv, ext = 32'h1234_5678;
  logic [59:0] p_out = 60'h800000000000080, p_in;
  logic [5:0] qdo = 6'h00, qoe = 6'h00;
  logic [1:0] den = 2'h0, ddo = 2'h0, doe = 2'h0, pwm = 2'h0;
  iop_pkg::iop_pad_s pad;
  int bad_count = 0, cmp_count = 0;
  iop_pin_router DUT (.clk_in(clk_in), .nrst_in(nrst_in),
    .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wd), .avs_byteenable_in(4'hf),
    .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq),
    .pad_in_in(lvl), .pad_out(pad), .periph_out_in(p_out),
    .periph_in_out(p_in), .fixed_level_out(flv), .qspi_clk_en_in(qen),
    .qspi_do_in(qdo), .qspi_oe_in(qoe), .dbg_en_in(den),
    .dbg_dio_do_in(ddo), .dbg_dio_oe_in(doe), .int_clk_in(4'hf),
    .pwm_in(pwm), .sleep_in(slp));
  iop_far_side u_far (.pad_in(pad), .ext_in(ext), .level_out(lvl));
  // Clock
  always #5 clk_in = ~clk_in;
  task automatic test_done();
    $display("Compares %0d, errors %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // One bus transfer, held until waitrequest is sampled low
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    @(posedge clk_in);
    wr <= w;
    rd <= !w;
    addr <= a;
    wd <= d;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_in);
      if (waitreq === 1'b0) break;
    end
    got = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    if (n == 50) begin
      bad_count++;
      $display("Error at %0t: bus timeout", $time);
      test_done();
    end
  endtask
  function automatic logic [31:0] mode(input logic [1:0] d,
    input logic [5:0] s);
    return {22'h0, d, 2'h0, s};
  endfunction
  // Main sequence
  initial begin
    repeat (20) @(posedge clk_in);
    nrst_in <= 1'b1;
    xfer(1'b0, 8'h8c, 32'h0);
    chk(got, 32'h0000_ffff);
    xfer(1'b1, 8'h0c, mode(2'h0, iop_pkg::SEL_ANALOG));
    xfer(1'b1, 8'h30, mode(2'h0, 6'h05));
    xfer(1'b1, 8'h34, mode(2'h0, 6'h05));
    repeat (8) @(posedge clk_in);
    xfer(1'b0, 8'h80, 32'h0);
    chk(got, 32'h0000_5670);
    chk({16'h0, flv[15:0]}, 32'h0000_5678);
    chk({31'h0, p_in[5]}, 32'h1);
    xfer(1'b1, 8'h30, mode(2'h0, 6'h00));
    xfer(1'b1, 8'h38, mode(2'h3, 6'h07));
    xfer(1'b1, 8'h3c, mode(2'h3, iop_pkg::SEL_MAX));
    xfer(1'b1, 8'h40, mode(2'h1, 6'h00));
    repeat (8) @(posedge clk_in);
    chk({31'h0, p_in[5]}, 32'h0);
    chk({30'h0, pad.oe[15:14]}, 32'h3);
    chk({30'h0, pad.dout[15:14]}, 32'h3);
    chk({31'h0, pad.pu[16]}, 32'h1);
    for (int i = 16; i < 32; i++) begin
      xfer(1'b1, 8'(4 * i), mode(2'h3, 6'h00));
    end
    xfer(1'b1, 8'ha0, 32'h0000_a5c3);
    repeat (3) @(posedge clk_in);
    chk({16'h0, pad.dout[31:16]}, 32'h0000_a5c3);
    chk({31'h0, pad.pu[16]}, 32'h0);
    repeat (5) @(posedge clk_in);
    xfer(1'b0, 8'ha0, 32'h0);
    chk(got, 32'h0000_a5c3);
    xfer(1'b1, 8'ha4, 32'h0000_0011);
    xfer(1'b1, 8'ha8, 32'h0000_0003);
    repeat (3) @(posedge clk_in);
    chk({16'h0, pad.dout[31:16]}, 32'h0000_a5d0);
    xfer(1'b1, 8'hb4, 32'h0000_0001);
    xfer(1'b1, 8'ha0, 32'h0000_ffff);
    slp <= 1'b1;
    repeat (3) @(posedge clk_in);
    chk({16'h0, pad.dout[31:16]}, 32'h0000_fffe);
    slp <= 1'b0;
    xfer(1'b0, 8'hac, 32'h0);
    chk(got, 32'h0000_fffe);
    xfer(1'b1, 8'hb0, 32'h0000_0001);
    repeat (3) @(posedge clk_in);
    chk({16'h0, pad.dout[31:16]}, 32'h0000_ffff);
    xfer(1'b1, 8'hf0, 32'hffff_ffff);
    xfer(1'b0, 8'hf0, 32'h0);
    chk(got, 32'h0);
    xfer(1'b0, 8'h40, 32'h0);
    chk(got, 32'h0000_0300);
    xfer(1'b1, 8'h94, 32'h0000_0004);
    qen <= 1'b1;
    qdo <= 6'h3f;
    qoe <= 6'h3f;
    repeat (3) @(posedge clk_in);
    chk({26'h0, pad.dout[5:0]}, 32'h3f);
    qen <= 1'b0;
    den <= 2'h3;
    ddo <= 2'h1;
    doe <= 2'h3;
    repeat (3) @(posedge clk_in);
    chk({28'h0, pad.oe[9:6]}, 32'h5);
    chk({30'h0, pad.dout[8], pad.dout[6]}, 32'h1);
    den <= 2'h0;
    chk({31'h0, pad.oe[11]}, 32'h0);
    xfer(1'b1, 8'hc0, 32'h0000_0002);
    repeat (3) @(posedge clk_in);
    chk({31'h0, pad.oe[11]}, 32'h1);
    xfer(1'b1, 8'hc4, 32'h0000_0001);
    pwm <= 2'h1;
    slp <= 1'b1;
    repeat (3) @(posedge clk_in);
    chk({30'h0, pad.oe[12], pad.dout[12]}, 32'h3);
    slp <= 1'b0;
    test_done();
  end
endmodule
